// File: verilog/pst_defs.svh
`ifndef PST_DEFS_SVH
`define PST_DEFS_SVH

// table page register reset value and the bit that picks configuration space
`define PST_PAGE_RST     8'h00
`define PST_PAGE_CFG_BIT 7

// data word, upper program byte and page widths
`define PST_WORD_W 16
`define PST_HI_W   8
`define PST_PAGE_W 8

// default word-index width of the program store, space bit included
`define PST_MEM_AW 13

// cycles from a taken read to its result on the output
`define PST_RD_LATENCY 2

`endif

// File: verilog/pst_pkg.sv
package pst_pkg;

  // table operation kinds, gray coded along read low, read high, write high, write low
  typedef enum logic [1:0] {
    pst_table_read_low   = 2'h0,
    pst_table_read_high  = 2'h1,
    pst_table_write_high = 2'h3,
    pst_table_write_low  = 2'h2
  } pst_op_t;

endpackage

// File: verilog/pst_mem_if.sv
`timescale 1ns/1ps

// request and read-back signals between the table access logic and the program store
interface pst_mem_if #(
  parameter int AW = 13
);
  logic          en;
  logic [AW-1:0] addr;
  logic [1:0]    we_lo;
  logic          we_hi;
  logic [15:0]   wdata_lo;
  logic [7:0]    wdata_hi;
  logic [15:0]   rdata_lo;
  logic [7:0]    rdata_hi;

  modport ctrl (
    output en,
    output addr,
    output we_lo,
    output we_hi,
    output wdata_lo,
    output wdata_hi,
    input  rdata_lo,
    input  rdata_hi
  );

  modport mem (
    input  en,
    input  addr,
    input  we_lo,
    input  we_hi,
    input  wdata_lo,
    input  wdata_hi,
    output rdata_lo,
    output rdata_hi
  );
endinterface

// File: verilog/pst_prog_mem.sv
`timescale 1ns/1ps
`include "pst_defs.svh"

module pst_prog_mem #(
  parameter int AW = `PST_MEM_AW
) (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  // store port
  pst_mem_if.mem   mem_port
);

  localparam int DEPTH = 1 << AW;

  // low word kept as two byte lanes so a byte write leaves its neighbour alone
  logic [7:0] lo_b0_mem [DEPTH];
  logic [7:0] lo_b1_mem [DEPTH];
  logic [7:0] hi_mem    [DEPTH];

  logic [15:0] rdata_lo_reg;
  logic [7:0]  rdata_hi_reg;

  // writes; array contents have no reset, like a real program store
  always_ff @(posedge sys_clk_in) begin
    if (mem_port.we_lo[0]) begin
      lo_b0_mem[mem_port.addr] <= mem_port.wdata_lo[7:0];
    end
    if (mem_port.we_lo[1]) begin
      lo_b1_mem[mem_port.addr] <= mem_port.wdata_lo[15:8];
    end
    if (mem_port.we_hi) begin
      hi_mem[mem_port.addr] <= mem_port.wdata_hi;
    end
  end

  // registered read, old data on a same-cycle write
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      rdata_lo_reg <= 16'h0000;
      rdata_hi_reg <= 8'h00;
    end else if (mem_port.en) begin
      rdata_lo_reg <= {lo_b1_mem[mem_port.addr], lo_b0_mem[mem_port.addr]};
      rdata_hi_reg <= hi_mem[mem_port.addr];
    end
  end

  assign mem_port.rdata_lo = rdata_lo_reg;
  assign mem_port.rdata_hi = rdata_hi_reg;

endmodule

// File: verilog/pst_table_access.sv
// Summary of operation
// - Low table reads and writes reach bits 15 to 0 of any program word on their own path.
// - The upper program byte is read or written only by the high table operations.
// - Program addresses step by two per 24-bit word, so address bit 0 is not a word bit.
// - Program words are two side-by-side 16-bit spaces, low ops on one, high ops on the other.
// - A word-mode low read returns program bits 15 to 0 unchanged.
// - A byte-mode low read returns the byte chosen by byte select in the low result byte.
// - A word-mode high read returns program bits 23 to 16 low and zero in bits 15 to 8.
// - A byte-mode high read returns the upper byte for select zero and zero for select one.
// - Low table writes store one byte or a full word; high table writes store the upper byte, and a byte write with select one is dropped.
// - Every table access takes its region from the table page register.
// - Page bit 7 clear selects user space and set selects configuration space.
`timescale 1ns/1ps
`include "pst_defs.svh"

module pst_table_access #(
  parameter int MEM_AW = `PST_MEM_AW
) (
  // clock and reset
  input  wire logic                       sys_clk_in,
  input  wire logic                       rst_n_in,
  // table page register load
  input  wire logic                       page_wr_in,
  input  wire logic [`PST_PAGE_W-1:0]     page_wdata_in,
  // table operation request
  input  wire logic                       op_valid_in,
  input  wire pst_pkg::pst_op_t           op_kind_in,
  input  wire logic                       op_byte_in,
  input  wire logic [`PST_WORD_W-1:0]     op_addr_in,
  input  wire logic [`PST_WORD_W-1:0]     op_wdata_in,
  // read result and page state
  output logic      [`PST_WORD_W-1:0]     rdata_out,
  output logic                            rdata_valid_out,
  output logic      [`PST_PAGE_W-1:0]     page_out,
  output logic                            cfg_space_out
);

  // word index: space bit from the page, then the low MEM_AW-1 bits of page low bits and address bits 15..1
  function automatic logic [MEM_AW-1:0] word_index(input logic [`PST_PAGE_W-1:0] page,
                                                   input logic [`PST_WORD_W-1:0] ea);
    logic [21:0] lin;
    lin        = {page[6:0], ea[15:1]};
    word_index = {page[`PST_PAGE_CFG_BIT], lin[MEM_AW-2:0]};
  endfunction

  // shape the stored word into the 16-bit result
  function automatic logic [15:0] shape_read(input logic        hi_op,
                                             input logic        byte_op,
                                             input logic        bsel,
                                             input logic [15:0] lo_word,
                                             input logic [7:0]  hi_byte);
    logic [15:0] res;
    res = 16'h0000;
    if (!hi_op && !byte_op) begin
      res = lo_word;
    end else if (!hi_op) begin
      res = {8'h00, (bsel ? lo_word[15:8] : lo_word[7:0])};
    end else if (!byte_op) begin
      res = {8'h00, hi_byte};
    end else begin
      res = {8'h00, (bsel ? 8'h00 : hi_byte)};
    end
    shape_read = res;
  endfunction

  pst_mem_if #(.AW(MEM_AW)) mif ();

  pst_prog_mem #(
    .AW (MEM_AW)
  ) u_mem (
    .sys_clk_in (sys_clk_in),
    .rst_n_in   (rst_n_in),
    .mem_port   (mif)
  );

  logic [`PST_PAGE_W-1:0] page_reg;
  logic [`PST_PAGE_W-1:0] page_next;
  logic                   cfg_reg;
  logic                   cfg_next;
  logic                   s1_valid_reg;
  logic                   s1_valid_next;
  logic                   s1_hi_reg;
  logic                   s1_hi_next;
  logic                   s1_byte_reg;
  logic                   s1_byte_next;
  logic                   s1_bsel_reg;
  logic                   s1_bsel_next;
  logic [15:0]            rdata_reg;
  logic [15:0]            rdata_next;
  logic                   rvalid_reg;
  logic                   rvalid_next;
  logic                   op_bsel;
  logic                   op_is_read;

  // byte select comes straight from the effective address
  assign op_bsel    = op_addr_in[0];
  assign op_is_read = (op_kind_in == pst_pkg::pst_table_read_low) ||
                      (op_kind_in == pst_pkg::pst_table_read_high);

  // page register next value; an op in the same cycle still uses the old page
  always_comb begin
    page_next = page_reg;
    if (page_wr_in) begin
      page_next = page_wdata_in;
    end
    cfg_next = page_next[`PST_PAGE_CFG_BIT];
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      page_reg <= `PST_PAGE_RST;
      cfg_reg  <= 1'b0;
    end else begin
      page_reg <= page_next;
      cfg_reg  <= cfg_next;
    end
  end

  // store request; this path is separate from any data-space access
  always_comb begin
    mif.en       = op_valid_in;
    mif.addr     = word_index(page_reg, op_addr_in);
    mif.we_lo    = 2'h0;
    mif.we_hi    = 1'b0;
    mif.wdata_lo = 16'h0000;
    mif.wdata_hi = op_wdata_in[7:0];
    // no store write is taken while reset holds, so a stray op cannot corrupt a word
    if (op_valid_in && rst_n_in) begin
      case (op_kind_in)
        pst_pkg::pst_table_write_low: begin
          // low space only; byte data replicated so either lane can take it
          if (op_byte_in) begin
            mif.we_lo    = op_bsel ? 2'h2 : 2'h1;
            mif.wdata_lo = {op_wdata_in[7:0], op_wdata_in[7:0]};
          end else begin
            mif.we_lo    = 2'h3;
            mif.wdata_lo = op_wdata_in;
          end
        end
        pst_pkg::pst_table_write_high: begin
          // a byte write to the phantom byte has nowhere to go and is dropped
          mif.we_hi = !op_byte_in || !op_bsel;
        end
        default: begin
          mif.we_lo = 2'h0;
        end
      endcase
    end
  end

  // read pipeline: stage 1 waits on the store, stage 2 registers the shaped result
  always_comb begin
    s1_valid_next = op_valid_in && op_is_read;
    s1_hi_next    = op_kind_in == pst_pkg::pst_table_read_high;
    s1_byte_next  = op_byte_in;
    s1_bsel_next  = op_bsel;
    rvalid_next   = s1_valid_reg;
    rdata_next    = rdata_reg;
    if (s1_valid_reg) begin
      rdata_next = shape_read(s1_hi_reg, s1_byte_reg, s1_bsel_reg,
                              mif.rdata_lo, mif.rdata_hi);
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      s1_valid_reg <= 1'b0;
      s1_hi_reg    <= 1'b0;
      s1_byte_reg  <= 1'b0;
      s1_bsel_reg  <= 1'b0;
      rvalid_reg   <= 1'b0;
      rdata_reg    <= 16'h0000;
    end else begin
      s1_valid_reg <= s1_valid_next;
      s1_hi_reg    <= s1_hi_next;
      s1_byte_reg  <= s1_byte_next;
      s1_bsel_reg  <= s1_bsel_next;
      rvalid_reg   <= rvalid_next;
      rdata_reg    <= rdata_next;
    end
  end

  // outputs straight from flops; the result holds until the next read lands
  assign rdata_out       = rdata_reg;
  assign rdata_valid_out = rvalid_reg;
  assign page_out        = page_reg;
  assign cfg_space_out   = cfg_reg;

  // helper copies so sampled-value functions see whole signals
  logic        chk_bsel;
  logic [7:0]  chk_lo_b1;
  logic [7:0]  chk_lo_b0;
  logic [MEM_AW-1:0] chk_index;
  logic [22:0]       chk_full;
  assign chk_bsel  = op_addr_in[0];
  assign chk_lo_b1 = mif.rdata_lo[15:8];
  assign chk_lo_b0 = mif.rdata_lo[7:0];
  // expected index rebuilt from page and byte address, kept apart from word_index
  assign chk_full  = {page_out[6:0], op_addr_in};
  assign chk_index = {page_out[`PST_PAGE_CFG_BIT], chk_full[MEM_AW-1:1]};

  sequence s_rd_lo(logic b);
    op_valid_in && op_kind_in == pst_pkg::pst_table_read_low && op_byte_in == b;
  endsequence

  sequence s_rd_hi(logic b);
    op_valid_in && op_kind_in == pst_pkg::pst_table_read_high && op_byte_in == b;
  endsequence

  sequence s_wr_hi;
    op_valid_in && op_kind_in == pst_pkg::pst_table_write_high;
  endsequence

  property p_rd_lo_word;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    s_rd_lo(1'b0) |-> ##2 (rdata_valid_out && rdata_out == $past(mif.rdata_lo));
  endproperty
  a_rd_lo_word: assert property (p_rd_lo_word)
    else $error("low word read result wrong");

  property p_rd_lo_byte;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    s_rd_lo(1'b1) |-> ##2 (rdata_valid_out && rdata_out ==
      {8'h00, ($past(chk_bsel, 2) ? $past(chk_lo_b1) : $past(chk_lo_b0))});
  endproperty
  a_rd_lo_byte: assert property (p_rd_lo_byte)
    else $error("low byte read picked the wrong byte");

  property p_rd_hi_word;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    s_rd_hi(1'b0) |-> ##2 (rdata_valid_out && rdata_out == {8'h00, $past(mif.rdata_hi)});
  endproperty
  a_rd_hi_word: assert property (p_rd_hi_word)
    else $error("high word read result wrong");

  property p_rd_hi_byte;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    s_rd_hi(1'b1) |-> ##2 (rdata_valid_out && rdata_out ==
      ($past(chk_bsel, 2) ? 16'h0000 : {8'h00, $past(mif.rdata_hi)}));
  endproperty
  a_rd_hi_byte: assert property (p_rd_hi_byte)
    else $error("high byte read or phantom byte wrong");

  property p_hi_only_path;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    mif.we_hi |-> (op_valid_in && op_kind_in == pst_pkg::pst_table_write_high);
  endproperty
  a_hi_only_path: assert property (p_hi_only_path)
    else $error("upper byte written outside a high table write");

  property p_lo_write;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    (op_valid_in && op_kind_in == pst_pkg::pst_table_write_low) |->
      (mif.we_hi == 1'b0 && (op_byte_in ? (mif.we_lo == (chk_bsel ? 2'h2 : 2'h1))
                                        : (mif.we_lo == 2'h3 && mif.wdata_lo == op_wdata_in)));
  endproperty
  a_lo_write: assert property (p_lo_write)
    else $error("low table write lanes wrong");

  property p_addr_map;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    op_valid_in |-> (mif.en && mif.addr == chk_index);
  endproperty
  a_addr_map: assert property (p_addr_map)
    else $error("store address not built from page and address");

  property p_space_sel;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    op_valid_in |-> (mif.addr[MEM_AW-1] == page_out[`PST_PAGE_CFG_BIT]);
  endproperty
  a_space_sel: assert property (p_space_sel)
    else $error("space select does not follow page bit 7");

  property p_step_two;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    (op_valid_in && $stable(op_valid_in) && $stable(page_out) &&
     (op_addr_in[15:1] == $past(op_addr_in[15:1]))) |-> (mif.addr == $past(mif.addr));
  endproperty
  a_step_two: assert property (p_step_two)
    else $error("address bit 0 changed the program word");

  property p_valid_cause;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    rdata_valid_out |-> $past(op_valid_in && op_is_read, 2);
  endproperty
  a_valid_cause: assert property (p_valid_cause)
    else $error("result valid without a read two cycles earlier");

  property p_page_load;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    page_wr_in |=> (page_out == $past(page_wdata_in) &&
                    cfg_space_out == $past(page_wdata_in[`PST_PAGE_CFG_BIT]));
  endproperty
  a_page_load: assert property (p_page_load)
    else $error("page register load wrong");

  // high writes touch only the upper space; the phantom byte write is dropped
  property p_hi_write;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    s_wr_hi |-> (mif.we_lo == 2'h0 && mif.we_hi == (!op_byte_in || !chk_bsel) &&
                 mif.wdata_hi == op_wdata_in[7:0]);
  endproperty
  a_hi_write: assert property (p_hi_write)
    else $error("high table write lanes wrong");

  property p_rd_no_write;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    (op_valid_in && op_is_read) |-> (mif.we_lo == 2'h0 && !mif.we_hi);
  endproperty
  a_rd_no_write: assert property (p_rd_no_write)
    else $error("table read wrote the store");

  property p_reset_out;
    @(posedge sys_clk_in)
    !rst_n_in |=> (!rdata_valid_out && page_out == `PST_PAGE_RST && !cfg_space_out);
  endproperty
  a_reset_out: assert property (p_reset_out)
    else $error("outputs not at reset values after reset");

endmodule

// File: dv/pst_core_model.sv
`timescale 1ns/1ps

// core side: one table op and/or page load per call, launched 1 ns after the edge
module pst_core_model (
  // clock
  input  wire logic        sys_clk_in,
  // requests toward the table access block
  output logic             page_wr_out,
  output logic [7:0]       page_wdata_out,
  output logic             op_valid_out,
  output pst_pkg::pst_op_t op_kind_out,
  output logic             op_byte_out,
  output logic [15:0]      op_addr_out,
  output logic [15:0]      op_wdata_out
);
  initial begin
    page_wr_out    = 1'b0;
    page_wdata_out = 8'h00;
    op_valid_out   = 1'b0;
    op_kind_out    = pst_pkg::pst_table_read_low;
    op_byte_out    = 1'b0;
    op_addr_out    = 16'h0000;
    op_wdata_out   = 16'h0000;
  end

  // back to back calls give one request every cycle, each held for one cycle
  task automatic op(input logic v, input pst_pkg::pst_op_t k, input logic b,
                    input logic [15:0] a, input logic [15:0] d, input logic pw,
                    input logic [7:0] pv);
    @(posedge sys_clk_in);
    #1;
    op_valid_out   = v;
    op_kind_out    = k;
    op_byte_out    = b;
    op_addr_out    = a;
    op_wdata_out   = d;
    page_wr_out    = pw;
    page_wdata_out = pv;
  endtask

  // idle: data lines toggle so a stale value is never mistaken for a live one
  task automatic idle();
    @(posedge sys_clk_in);
    #1;
    op_valid_out = 1'b0;
    page_wr_out  = 1'b0;
    op_wdata_out = ~op_wdata_out;
    op_addr_out  = ~op_addr_out;
  endtask
endmodule

// File: dv/testbench.sv
`timescale 1ns/1ps

module testbench;
  typedef struct {logic [15:0] val; int due;} pst_exp_t;
  logic             sys_clk_in = 1'b0;
  logic             rst_n_in   = 1'b0;
  logic             page_wr;
  logic [7:0]       page_wdata;
  logic             op_valid;
  pst_pkg::pst_op_t op_kind;
  logic             op_byte;
  logic [15:0]      op_addr;
  logic [15:0]      op_wdata;
  logic [15:0]      rdata_out;
  logic             rdata_valid_out;
  logic [7:0]       page_out;
  logic             cfg_space_out;
  int               error_cnt = 0;
  int               checked = 0;
  int               cyc = 0;
  int               key;
  logic [15:0]      lo_m[int];
  logic [7:0]       hi_m[int];
  logic [7:0]       page_m = 8'h00;
  logic [11:0]      words[8];
  pst_exp_t         exp_q[$];
  pst_exp_t         e;

  always #5 sys_clk_in = ~sys_clk_in;

  pst_core_model pst_core_model_inst (
    .sys_clk_in(sys_clk_in), .page_wr_out(page_wr), .page_wdata_out(page_wdata),
    .op_valid_out(op_valid), .op_kind_out(op_kind), .op_byte_out(op_byte),
    .op_addr_out(op_addr), .op_wdata_out(op_wdata));

  pst_table_access #(.MEM_AW(13)) pst_table_access_inst (
    .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .page_wr_in(page_wr),
    .page_wdata_in(page_wdata), .op_valid_in(op_valid), .op_kind_in(op_kind),
    .op_byte_in(op_byte), .op_addr_in(op_addr), .op_wdata_in(op_wdata),
    .rdata_out(rdata_out), .rdata_valid_out(rdata_valid_out), .page_out(page_out),
    .cfg_space_out(cfg_space_out));

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // reference read result from the two side-by-side word spaces
  function automatic logic [15:0] rd_model(pst_pkg::pst_op_t k, logic b, logic s, int key);
    if (k == pst_pkg::pst_table_read_low) begin
      if (!b) return lo_m[key];
      return {8'h00, s ? lo_m[key][15:8] : lo_m[key][7:0]};
    end
    if (b && s) return 16'h0000;
    return {8'h00, hi_m[key]};
  endfunction

  // monitor at the falling edge, where inputs and registered outputs are settled
  always @(negedge sys_clk_in) begin
    cyc++;
    if (cyc > 2000) begin
      error_cnt++;
      $display("CHECK FAILED run length expected finish seen hang");
      print_verdict();
    end
    if (rdata_valid_out === 1'b1 && exp_q.size() == 0) begin
      check("unexpected read result", 16'h0000, 16'h0001);
    end else if (rdata_valid_out === 1'b1) begin
      e = exp_q.pop_front();
      check("read latency", e.due[15:0], cyc[15:0]);
      check("read data", e.val, rdata_out);
    end else if (exp_q.size() > 0 && exp_q[0].due <= cyc) begin
      e = exp_q.pop_front();
      check("read valid missing", 16'h0001, 16'h0000);
    end
    if (rst_n_in) begin
      check("page", {8'h00, page_m}, {8'h00, page_out});
      check("cfg space", {15'h0000, page_m[7]}, {15'h0000, cfg_space_out});
    end
    if (rst_n_in && op_valid) begin
      // word index: space bit, then address bits 12 to 1 above the byte select
      key = int'({page_m[7], op_addr[12:1]});
      case (op_kind)
        pst_pkg::pst_table_write_low: begin
          if (!op_byte) lo_m[key] = op_wdata;
          else if (op_addr[0]) lo_m[key][15:8] = op_wdata[7:0];
          else lo_m[key][7:0] = op_wdata[7:0];
        end
        pst_pkg::pst_table_write_high: begin
          if (!(op_byte && op_addr[0])) hi_m[key] = op_wdata[7:0];
        end
        default: exp_q.push_back('{rd_model(op_kind, op_byte, op_addr[0], key), cyc + 2});
      endcase
    end
    if (rst_n_in && page_wr) page_m = page_wdata;
  end

  // random traffic: back to back ops over the initialised words, page flips mixed in
  task automatic rnd_ops(input int n);
    for (int i = 0; i < n; i++) begin
      pst_core_model_inst.op(($urandom % 4) != 0, pst_pkg::pst_op_t'($urandom % 4),
        1'($urandom), {3'($urandom), words[$urandom % 8], 1'($urandom)}, 16'($urandom),
        ($urandom % 8) == 0, 8'($urandom));
    end
  endtask

  initial begin
    void'($urandom(78));
    repeat (16) @(posedge sys_clk_in);
    check("reset rdata", 16'h0000, rdata_out);
    check("reset valid", 16'h0000, {15'h0000, rdata_valid_out});
    check("reset page", 16'h0000, {8'h00, page_out});
    #1;
    rst_n_in = 1'b1;
    $display("test reset done");
    // page loads across the space bit, each followed by a low and a high word write to each of the eight chosen words in that space
    foreach (words[i]) words[i] = 12'($urandom);
    for (int sp = 0; sp < 2; sp++) begin
      pst_core_model_inst.op(1'b0, pst_pkg::pst_table_read_low, 1'b0, 16'h0000, 16'h0000,
        1'b1, sp ? 8'hC5 : 8'h3A);
      foreach (words[i]) begin
        pst_core_model_inst.op(1'b1, pst_pkg::pst_table_write_low, 1'b0, {3'h0, words[i], 1'b0},
          16'($urandom), 1'b0, 8'h00);
        pst_core_model_inst.op(1'b1, pst_pkg::pst_table_write_high, 1'b0, {3'h0, words[i], 1'b1},
          16'($urandom), 1'b0, 8'h00);
      end
    end
    $display("test page and init done");
    // every op kind, mode and byte select on one word, four rounds: three in configuration space, one in user space
    for (int r = 0; r < 4; r++) begin
      for (int k = 0; k < 4; k++) begin
        for (int m = 0; m < 4; m++) begin
          pst_core_model_inst.op(1'b1, pst_pkg::pst_op_t'(k), m[1], {3'($urandom), words[0], m[0]},
            16'($urandom), k == 3 && m == 3, r[0] ? 8'h00 : 8'h80);
        end
      end
    end
    $display("test modes done");
    rnd_ops(400);
    $display("test random done");
    repeat (4) pst_core_model_inst.idle();
    check("reads outstanding", 16'h0000, 16'(exp_q.size()));
    print_verdict();
  end
endmodule
